// file: inc/meter_pkg.sv
// Constants shared by the energy accumulator design
package meter_pkg;
   localparam int PHASES = 3;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 64;
   localparam int VOLT_W = 16;
   localparam int PWR_W  = 24;
   localparam int ACC_W  = 64;

   // Accumulator bank layout
   localparam int N_ACC    = 19;
   localparam int IDX_NET  = 0;
   localparam int IDX_FWD  = 3;
   localparam int IDX_REV  = 6;
   localparam int IDX_VAR  = 9;
   localparam int IDX_VA   = 12;
   localparam int IDX_TREV = 15;
   localparam int IDX_TVAR = 16;
   localparam int IDX_TVA  = 17;
   localparam int IDX_LOCK = 18;
   localparam logic [N_ACC-1:0] RESETTABLE_MASK = 19'h3FFFF;

   // Energy wrap point, accumulators count watt-seconds
   localparam longint ENERGY_WRAP_GWH = 100;
   localparam longint WH_PER_GWH      = 1_000_000_000;
   localparam longint SEC_PER_HOUR    = 3600;
   localparam logic signed [ACC_W-1:0] ENERGY_WRAP_WS =
      ACC_W'(ENERGY_WRAP_GWH * WH_PER_GWH * SEC_PER_HOUR);

   // One-second strobe
   localparam int CLK_HZ         = 25_000_000;
   localparam int TICK_PERIOD_MS = 1000;
   localparam int TICK_CYCLES    = CLK_HZ / 1000 * TICK_PERIOD_MS;

   // Register offsets
   localparam logic [ADDR_W-1:0] ADDR_TOTAL_VARS_INT = 16'h053F;
   localparam logic [ADDR_W-1:0] ADDR_PWR_SCALE      = 16'h0649;
   localparam logic [ADDR_W-1:0] ADDR_AVG_LN         = 16'h0600;
   localparam logic [ADDR_W-1:0] ADDR_AVG_LL         = 16'h0601;
   localparam logic [ADDR_W-1:0] ADDR_FREQ           = 16'h0602;
   localparam logic [ADDR_W-1:0] ADDR_PF_BASE        = 16'h0603;
   localparam logic [ADDR_W-1:0] ADDR_PF_AVG         = 16'h0606;
   localparam logic [ADDR_W-1:0] ADDR_VARS_BASE      = 16'h0607;
   localparam logic [ADDR_W-1:0] ADDR_VA_BASE        = 16'h060A;
   localparam logic [ADDR_W-1:0] ADDR_TOTAL_VA       = 16'h060D;
   localparam logic [ADDR_W-1:0] ADDR_LL_BASE        = 16'h060E;
   localparam logic [ADDR_W-1:0] ADDR_ACTIVE         = 16'h0611;
   localparam logic [ADDR_W-1:0] ADDR_CLEAR          = 16'h06A0;
   localparam logic [ADDR_W-1:0] ADDR_SERVICE        = 16'h06A1;
   localparam logic [ADDR_W-1:0] ADDR_NOMINAL        = 16'h06A2;
   localparam logic [ADDR_W-1:0] ADDR_ACC_BASE       = 16'h0700;

   // Reset values and field codes
   localparam logic [15:0] PWR_SCALE_RST = 16'h0001;
   localparam logic [15:0] SCALE_X1      = 16'h0001;
   localparam logic [15:0] SCALE_X10     = 16'h000A;
   localparam logic [15:0] SCALE_X100    = 16'h0064;
   localparam logic [15:0] SCALE_X1000   = 16'h03E8;
   localparam logic [15:0] NOMINAL_RST   = 16'h04B0;
   localparam logic [1:0]  SERVICE_RST   = 2'h0;
   localparam logic [63:0] CLEAR_CODE    = 64'h0000_0000_0000_0001;
   localparam logic [19:0] ACTIVE_DIV    = 20'h00005;
   localparam logic [15:0] PF_UNITY      = 16'h0064;
   localparam logic [15:0] FREQ_DIV      = 16'h000A;

   // Line-to-line factors in Q9, indexed by service angle setting
   localparam logic [9:0] LL_FACTOR_120 = 10'h1BB;
   localparam logic [9:0] LL_FACTOR_180 = 10'h200;
   localparam logic [9:0] LL_FACTOR_90  = 10'h16A;
   localparam logic [9:0] LL_FACTOR_0   = 10'h000;
   localparam int         LL_SHIFT      = 9;
endpackage

// file: inc/energy_bank_if.sv
// Connection between control logic and the accumulator bank
`timescale 1ns/100ps
`default_nettype none
interface energy_bank_if;
   logic                                                   tick;
   logic                                                   clear;
   logic [meter_pkg::N_ACC-1:0]                            load;
   logic [meter_pkg::ACC_W-1:0]                            load_val;
   logic [meter_pkg::N_ACC-1:0][meter_pkg::ACC_W-1:0]      delta;
   logic [meter_pkg::N_ACC-1:0][meter_pkg::ACC_W-1:0]      value;

   modport ctrl (output tick, output clear, output load, output load_val, output delta, input value);
   modport bank (input tick, input clear, input load, input load_val, input delta, output value);
endinterface
`default_nettype wire

// file: src/energy_bank.sv
// Bank of energy accumulators with clear, preset and wrap
`timescale 1ns/100ps
`default_nettype none
module energy_bank (
   input  wire logic        mclk,
   input  wire logic        rst,
   energy_bank_if.bank      bus
);
   typedef struct packed {
      logic [meter_pkg::N_ACC-1:0][meter_pkg::ACC_W-1:0] acc;
   } bank_state_type;

   bank_state_type cur_ff;
   bank_state_type nxt_state;

   always_comb begin
      logic signed [meter_pkg::ACC_W-1:0] s;
      s = '0;
      nxt_state = cur_ff;
      for (int i = 0; i < meter_pkg::N_ACC; i++) begin
         s = $signed(cur_ff.acc[i]) + $signed(bus.delta[i]);
         if (s >= meter_pkg::ENERGY_WRAP_WS) begin
            s = s - meter_pkg::ENERGY_WRAP_WS;
         end else if (s <= -meter_pkg::ENERGY_WRAP_WS) begin
            s = s + meter_pkg::ENERGY_WRAP_WS;
         end
         if (bus.load[i] && meter_pkg::RESETTABLE_MASK[i]) begin
            nxt_state.acc[i] = bus.load_val;
         end else if (bus.clear && meter_pkg::RESETTABLE_MASK[i]) begin
            nxt_state.acc[i] = '0;
         end else if (bus.tick) begin
            nxt_state.acc[i] = s;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_state;
      end
   end

   assign bus.value = cur_ff.acc;
endmodule
`default_nettype wire

// file: src/meter_energy_accumulators.sv
// Result registers and energy accumulation control of the meter
`timescale 1ns/100ps
`default_nettype none
module meter_energy_accumulators #(
   parameter int TICK_CYCLES = meter_pkg::TICK_CYCLES
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic [15:0]  reg_addr,
   input  wire logic         reg_wr,
   input  wire logic         reg_rd,
   input  wire logic [63:0]  reg_wdata,
   output logic      [63:0]  reg_rdata,
   output logic              reg_rvalid,
   input  wire logic [47:0]  phase_volts,
   input  wire logic [15:0]  freq_centi_hz,
   input  wire logic [71:0]  phase_watts,
   input  wire logic [71:0]  phase_vars,
   input  wire logic [71:0]  phase_va,
   output logic              sec_tick
);
   localparam int CNT_W = $clog2(TICK_CYCLES);
   localparam int N     = meter_pkg::N_ACC;

   // Elaboration-time checks on parameters and bank layout
   if (TICK_CYCLES < 2) begin : g_bad_tick
      $error("TICK_CYCLES must be at least 2");
   end
   if (meter_pkg::PHASES != 3) begin : g_bad_phases
      $error("three phases expected");
   end
   if (meter_pkg::VOLT_W * meter_pkg::PHASES != 48) begin : g_bad_volt_w
      $error("voltage port width mismatch");
   end
   if (meter_pkg::PWR_W * meter_pkg::PHASES != 72) begin : g_bad_pwr_w
      $error("power port width mismatch");
   end
   if (meter_pkg::DATA_W != meter_pkg::ACC_W) begin : g_bad_data_w
      $error("register data must hold one accumulator");
   end
   if (meter_pkg::N_ACC != meter_pkg::IDX_LOCK + 1 || meter_pkg::RESETTABLE_MASK[meter_pkg::IDX_LOCK]) begin : g_bad_bank
      $error("locked accumulator must be last and protected");
   end

   typedef struct packed {
      logic [CNT_W-1:0]  tick_cnt;
      logic              sec_tick;
      logic [63:0]       rdata;
      logic              rvalid;
      logic [15:0]       pwr_scale;
      logic [15:0]       nominal;
      logic [1:0]        service;
      logic [2:0]        active;
      logic [15:0]       avg_ln;
      logic [15:0]       avg_ll;
      logic [2:0][15:0]  ll_est;
      logic [15:0]       freq;
      logic [2:0][15:0]  pf;
      logic [15:0]       pf_avg;
      logic [2:0][15:0]  vars_int;
      logic [15:0]       tvars_int;
      logic [2:0][15:0]  va_int;
      logic [15:0]       tva_int;
      logic              clear;
      logic [N-1:0]      load;
      logic [63:0]       load_val;
   } meter_state_type;

   meter_state_type cur_ff;
   meter_state_type nxt_state;
   logic [N-1:0][63:0] dlt;

   energy_bank_if bank_bus ();

   energy_bank u_bank (
      .mclk (mclk),
      .rst  (rst),
      .bus  (bank_bus.bank)
   );

   // Divide by the scale multiplier and saturate to the integer range
   function automatic logic [15:0] scale_div(input logic signed [31:0] x, input logic [15:0] s);
      logic signed [31:0] q;
      q = x / $signed({16'h0000, s});
      if (q > 32'sh0000_7FFF) begin
         return 16'h7FFF;
      end
      if (q < 32'shFFFF_8001) begin
         return 16'h8001;
      end
      return q[15:0];
   endfunction

   // Power factor in hundredths with the sign of the real power

   function automatic logic [15:0] pf_calc(input logic signed [31:0] w, input logic [31:0] va);
      logic [31:0] mag;
      logic [31:0] q;
      mag = w[31] ? 32'(-w) : 32'(w);
      if (w == 32'sh0000_0000 || va == 32'h0000_0000) begin
         return meter_pkg::PF_UNITY;
      end
      q = 32'((40'(mag) * 40'(meter_pkg::PF_UNITY)) / 40'(va));
      if (q > 32'(meter_pkg::PF_UNITY)) begin
         q = 32'(meter_pkg::PF_UNITY);
      end
      return w[31] ? 16'(-q) : q[15:0];
   endfunction


   function automatic logic [63:0] sx16(input logic [15:0] v);
      return {{48{v[15]}}, v};
   endfunction

   always_comb begin
      logic [2:0]               act;
      logic [17:0]              ln_sum;
      logic [1:0]               n_act;
      logic [2:0][15:0]         volts;
      logic [2:0][31:0]         w;
      logic [2:0][31:0]         r;
      logic [2:0][31:0]         a;
      logic signed [31:0]       w_sum;
      logic signed [31:0]       r_sum;
      logic [31:0]              a_sum;
      logic [9:0]               factor;
      logic [27:0]              ll_prod;
      logic [17:0]              ll_sum;
      logic [15:0]              aoff;
      logic                     acc_hit;
      act     = '0;
      ln_sum  = '0;
      n_act   = '0;
      volts   = phase_volts;
      w       = '0;
      r       = '0;
      a       = '0;
      w_sum   = '0;
      r_sum   = '0;
      a_sum   = '0;
      factor  = '0;
      ll_prod = '0;
      ll_sum  = '0;
      aoff    = reg_addr - meter_pkg::ADDR_ACC_BASE;
      acc_hit = (reg_addr >= meter_pkg::ADDR_ACC_BASE) && (aoff < 16'(N));
      dlt     = '0;
      nxt_state = cur_ff;

      // One-second strobe
      if (cur_ff.tick_cnt == CNT_W'(TICK_CYCLES - 1)) begin
         nxt_state.tick_cnt = '0;
         nxt_state.sec_tick = 1'b1;
      end else begin
         nxt_state.tick_cnt = cur_ff.tick_cnt + 1'b1;
         nxt_state.sec_tick = 1'b0;
      end

      // Phase activity and per-phase quantities
      for (int p = 0; p < meter_pkg::PHASES; p++) begin
         act[p] = (20'(volts[p]) * meter_pkg::ACTIVE_DIV) > 20'(cur_ff.nominal);
         w[p] = act[p] ? {{8{phase_watts[p*24+23]}}, phase_watts[p*24 +: 24]} : 32'h0000_0000;
         r[p] = act[p] ? {{8{phase_vars[p*24+23]}}, phase_vars[p*24 +: 24]} : 32'h0000_0000;
         a[p] = act[p] ? {8'h00, phase_va[p*24 +: 24]} : 32'h0000_0000;
         if (act[p]) begin
            ln_sum = ln_sum + 18'(volts[p]);
            n_act  = n_act + 2'h1;
         end
         w_sum = w_sum + $signed(w[p]);
         r_sum = r_sum + $signed(r[p]);
         a_sum = a_sum + a[p];
         nxt_state.pf[p] = act[p] ? pf_calc($signed(w[p]), a[p]) : 16'h0000;
         nxt_state.vars_int[p] = scale_div($signed(r[p]), cur_ff.pwr_scale);
         nxt_state.va_int[p] = scale_div($signed(a[p]), cur_ff.pwr_scale);
      end
      nxt_state.active = act;

      // Line-neutral average over active phases, tenths of volts
      case (n_act)
         2'h3: begin
            nxt_state.avg_ln = 16'(ln_sum / 18'h00003);
         end
         2'h2: begin
            nxt_state.avg_ln = 16'(ln_sum >> 1);
         end
         2'h1: begin
            nxt_state.avg_ln = 16'(ln_sum);
         end
         default: begin
            nxt_state.avg_ln = 16'h0000;
         end
      endcase

      // Line-line estimates from phase pairs and service angle
      case (cur_ff.service)
         2'h0: begin
            factor = meter_pkg::LL_FACTOR_120;
         end
         2'h1: begin
            factor = meter_pkg::LL_FACTOR_180;
         end
         2'h2: begin
            factor = meter_pkg::LL_FACTOR_90;
         end
         default: begin
            factor = meter_pkg::LL_FACTOR_0;
         end
      endcase
      for (int p = 0; p < meter_pkg::PHASES; p++) begin
         ll_prod = (28'(volts[p]) + 28'(volts[(p + 1) % meter_pkg::PHASES])) * 28'(factor);
         nxt_state.ll_est[p] = 16'(ll_prod >> meter_pkg::LL_SHIFT);
         ll_sum = ll_sum + 18'(nxt_state.ll_est[p]);
      end
      nxt_state.avg_ll = 16'(ll_sum / 18'h00003);

      nxt_state.freq = freq_centi_hz / meter_pkg::FREQ_DIV;

      // Totals
      if (act == 3'h0) begin
         nxt_state.pf_avg = 16'h0000;
      end else begin
         nxt_state.pf_avg = pf_calc(w_sum, a_sum);
      end
      nxt_state.tvars_int = scale_div(r_sum, cur_ff.pwr_scale);
      nxt_state.tva_int = scale_div($signed(a_sum), cur_ff.pwr_scale);

      // Energy for this second, watt-seconds per accumulator
      for (int p = 0; p < meter_pkg::PHASES; p++) begin
         dlt[meter_pkg::IDX_NET + p] = {{32{w[p][31]}}, w[p]};
         dlt[meter_pkg::IDX_FWD + p] = $signed(w[p]) > 0 ? {32'h0000_0000, w[p]} : 64'h0;
         dlt[meter_pkg::IDX_REV + p] = $signed(w[p]) < 0 ? {32'h0000_0000, 32'(-w[p])} : 64'h0;
         dlt[meter_pkg::IDX_VAR + p] = {{32{r[p][31]}}, r[p]};
         dlt[meter_pkg::IDX_VA + p] = {32'h0000_0000, a[p]};
      end
      dlt[meter_pkg::IDX_TREV] = w_sum < 0 ? {32'h0000_0000, 32'(-w_sum)} : 64'h0;
      dlt[meter_pkg::IDX_LOCK] = dlt[meter_pkg::IDX_TREV];
      dlt[meter_pkg::IDX_TVAR] = {{32{r_sum[31]}}, r_sum};
      dlt[meter_pkg::IDX_TVA] = {32'h0000_0000, a_sum};

      // Register writes
      nxt_state.clear    = 1'b0;
      nxt_state.load     = '0;
      nxt_state.load_val = reg_wdata;
      if (reg_wr) begin
         case (reg_addr)
            meter_pkg::ADDR_PWR_SCALE: begin
               case (reg_wdata[15:0])
                  meter_pkg::SCALE_X1,
                  meter_pkg::SCALE_X10,
                  meter_pkg::SCALE_X100,
                  meter_pkg::SCALE_X1000: begin
                     nxt_state.pwr_scale = reg_wdata[15:0];
                  end
                  default: begin
                     nxt_state.pwr_scale = cur_ff.pwr_scale;
                  end
               endcase
            end
            meter_pkg::ADDR_CLEAR: begin
               nxt_state.clear = (reg_wdata == meter_pkg::CLEAR_CODE);
            end
            meter_pkg::ADDR_SERVICE: begin
               nxt_state.service = reg_wdata[1:0];
            end
            meter_pkg::ADDR_NOMINAL: begin
               nxt_state.nominal = reg_wdata[15:0];
            end
            default: begin
               if (acc_hit) begin
                  nxt_state.load[aoff[4:0]] = meter_pkg::RESETTABLE_MASK[aoff[4:0]];
               end
            end
         endcase
      end

      // Register reads, answered one cycle later
      nxt_state.rvalid = reg_rd;
      nxt_state.rdata  = 64'h0;
      if (reg_rd) begin
         case (reg_addr)
            meter_pkg::ADDR_TOTAL_VARS_INT: nxt_state.rdata = sx16(cur_ff.tvars_int);
            meter_pkg::ADDR_PWR_SCALE:      nxt_state.rdata = {48'h0, cur_ff.pwr_scale};
            meter_pkg::ADDR_AVG_LN:         nxt_state.rdata = {48'h0, cur_ff.avg_ln};
            meter_pkg::ADDR_AVG_LL:         nxt_state.rdata = {48'h0, cur_ff.avg_ll};
            meter_pkg::ADDR_FREQ:           nxt_state.rdata = {48'h0, cur_ff.freq};
            meter_pkg::ADDR_PF_AVG:         nxt_state.rdata = sx16(cur_ff.pf_avg);
            meter_pkg::ADDR_TOTAL_VA:       nxt_state.rdata = {48'h0, cur_ff.tva_int};
            meter_pkg::ADDR_ACTIVE:         nxt_state.rdata = {61'h0, cur_ff.active};
            meter_pkg::ADDR_SERVICE:        nxt_state.rdata = {62'h0, cur_ff.service};
            meter_pkg::ADDR_NOMINAL:        nxt_state.rdata = {48'h0, cur_ff.nominal};
            default: begin
               for (int p = 0; p < meter_pkg::PHASES; p++) begin
                  if (reg_addr == meter_pkg::ADDR_PF_BASE + 16'(p)) begin
                     nxt_state.rdata = sx16(cur_ff.pf[p]);
                  end
                  if (reg_addr == meter_pkg::ADDR_VARS_BASE + 16'(p)) begin
                     nxt_state.rdata = sx16(cur_ff.vars_int[p]);
                  end
                  if (reg_addr == meter_pkg::ADDR_VA_BASE + 16'(p)) begin
                     nxt_state.rdata = {48'h0, cur_ff.va_int[p]};
                  end
                  if (reg_addr == meter_pkg::ADDR_LL_BASE + 16'(p)) begin
                     nxt_state.rdata = {48'h0, cur_ff.ll_est[p]};
                  end
               end
               if (acc_hit) begin
                  nxt_state.rdata = bank_bus.value[aoff[4:0]];
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         cur_ff           <= '0;
         cur_ff.pwr_scale <= meter_pkg::PWR_SCALE_RST;
         cur_ff.nominal   <= meter_pkg::NOMINAL_RST;
         cur_ff.service   <= meter_pkg::SERVICE_RST;
      end else begin
         cur_ff <= nxt_state;
      end
   end

   // Accumulator bank control, all entries step on the same strobe
   assign bank_bus.tick     = cur_ff.sec_tick;
   assign bank_bus.clear    = cur_ff.clear;
   assign bank_bus.load     = cur_ff.load;
   assign bank_bus.load_val = cur_ff.load_val;
   assign bank_bus.delta    = dlt;

   assign reg_rdata  = cur_ff.rdata;
   assign reg_rvalid = cur_ff.rvalid;
   assign sec_tick   = cur_ff.sec_tick;
endmodule
`default_nettype wire

// file: dv/meter_energy_accumulators_chk.sv
// Assertion checker bound to the meter accumulator top
`timescale 1ns/100ps
`default_nettype none
module meter_energy_accumulators_chk #(
   parameter int TICK_CYCLES = 16
) (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [63:0] reg_wdata,
   input  wire logic [63:0] reg_rdata,
   input  wire logic        reg_rvalid,
   input  wire logic [47:0] phase_volts,
   input  wire logic [15:0] freq_centi_hz,
   input  wire logic [71:0] phase_watts,
   input  wire logic [71:0] phase_vars,
   input  wire logic [71:0] phase_va,
   input  wire logic        sec_tick
);
   int   gap_ff;
   logic seen_ff;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // Cycles since the previous strobe
   always_ff @(posedge mclk) begin
      if (rst) begin
         gap_ff <= 0;
         seen_ff <= 1'b0;
      end else if (sec_tick) begin
         gap_ff <= 1;
         seen_ff <= 1'b1;
      end else begin
         gap_ff <= gap_ff + 1;
      end
   end
   a_read_answer: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
   a_answer_cause: assert property (reg_rvalid |-> $past(reg_rd)) else $error("answer without read");
   a_idle_data_zero: assert property (!reg_rvalid |-> reg_rdata == 64'h0) else $error("idle data nonzero");
   a_tick_spacing: assert property (sec_tick && seen_ff |-> gap_ff == TICK_CYCLES)
      else $error("strobe spacing wrong");
   a_tick_pulse: assert property (sec_tick |=> !sec_tick) else $error("strobe too long");
   a_scale_legal: assert property (reg_rd && reg_addr == meter_pkg::ADDR_PWR_SCALE |=>
      reg_rdata inside {64'h1, 64'hA, 64'h64, 64'h3E8}) else $error("illegal scale value");
   a_clear_reads_zero: assert property (reg_rd && reg_addr == meter_pkg::ADDR_CLEAR |=>
      reg_rdata == 64'h0) else $error("clear command readable");
   a_freq_tenths: assert property (reg_rd && reg_addr == meter_pkg::ADDR_FREQ && $stable(freq_centi_hz) |=>
      reg_rdata == 64'($past(freq_centi_hz) / meter_pkg::FREQ_DIV)) else $error("frequency result wrong");
   c_tick: cover property (sec_tick);
   c_clear: cover property (reg_wr && reg_addr == meter_pkg::ADDR_CLEAR && reg_wdata == 64'h1);
   c_lock_read: cover property (reg_rd && reg_addr == 16'h0712);
endmodule
bind meter_energy_accumulators meter_energy_accumulators_chk #(.TICK_CYCLES(TICK_CYCLES))
   meter_energy_accumulators_chk_i (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .phase_volts(phase_volts), .freq_centi_hz(freq_centi_hz), .phase_watts(phase_watts),
   .phase_vars(phase_vars), .phase_va(phase_va), .sec_tick(sec_tick));
`default_nettype wire

// file: dv/meter_energy_accumulators_tb.sv
// Self-checking bench for the meter accumulator block
`timescale 1ns/100ps
`default_nettype none
module meter_energy_accumulators_tb;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic [15:0] reg_addr = 16'h0000;
   logic        reg_wr = 1'b0;
   logic        reg_rd = 1'b0;
   logic [63:0] reg_wdata = 64'h0;
   logic [63:0] reg_rdata;
   logic        reg_rvalid;
   logic [47:0] phase_volts = 48'h0;
   logic [15:0] freq_centi_hz = 16'h1770;
   logic [71:0] phase_watts = 72'h0;
   logic [71:0] phase_vars = 72'h0;
   logic [71:0] phase_va = 72'h0;
   logic        sec_tick;
   int          num_errors = 0;
   int          n_checks = 0;
   int          seed = 1;
   longint      w[3], q[3], s[3], v[3], e[19];
   always #20 mclk = ~mclk;
   meter_energy_accumulators #(.TICK_CYCLES(16)) meter_energy_accumulators_i (.mclk(mclk), .rst(rst),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .phase_volts(phase_volts), .freq_centi_hz(freq_centi_hz),
      .phase_watts(phase_watts), .phase_vars(phase_vars), .phase_va(phase_va), .sec_tick(sec_tick));
   function automatic longint rnd(input longint n);
      return $unsigned($random(seed)) % n;
   endfunction
   function automatic longint sc(input longint x, input longint k);
      longint r;
      r = x / k;
      return r > 32767 ? 32767 : (r < -32767 ? -32767 : r);
   endfunction
   function automatic longint pf(input longint wt, input longint va, input bit act);
      longint m;
      m = wt < 0 ? -wt : wt;
      if (!act) return 0;
      if (wt == 0 || va == 0) return 100;
      m = m * 100 / va;
      if (m > 100) m = 100;
      return wt < 0 ? -m : m;
   endfunction
   task automatic chk(input string nm, input logic [63:0] exp, input logic [63:0] got);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [63:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask
   task automatic rdc(input logic [15:0] a, input logic [63:0] exp);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      chk($sformatf("rvalid %h", a), 64'h1, 64'(reg_rvalid));
      chk($sformatf("reg %h", a), exp, reg_rdata);
   endtask
   task automatic wtick;
      int k;
      k = 0;
      do begin
         @(posedge mclk);
         #1;
         k++;
      end while (sec_tick !== 1'b1 && k < 40);
      if (k >= 40) chk("tick", 64'h1, 64'h0);
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      num_errors++;
      conclude();
   end
   initial begin
      longint f[4] = '{443, 512, 362, 0};
      longint k[4] = '{1, 10, 100, 1000};
      longint ab, bc, ca, sm, fr;
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      rdc(meter_pkg::ADDR_PWR_SCALE, 64'h1);
      rdc(meter_pkg::ADDR_NOMINAL, 64'h4B0);
      rdc(16'h0500, 64'h0);
      for (int i = 0; i < 19; i++) rdc(meter_pkg::ADDR_ACC_BASE + 16'(i), 64'h0);
      $display("test reset values done");
      // Phase C stays below a fifth of nominal, active sum is negative
      w[0] = 10 + rnd(5000);
      w[1] = -(w[0] + 1 + rnd(5000));
      w[2] = rnd(5000);
      for (int p = 0; p < 3; p++) begin
         q[p] = rnd(20000) - 10000;
         s[p] = (w[p] < 0 ? -w[p] : w[p]) + rnd(5000);
         v[p] = p == 2 ? 200 : 1000 + rnd(1000);
      end
      phase_watts <= {24'(w[2]), 24'(w[1]), 24'(w[0])};
      phase_vars <= {24'(q[2]), 24'(q[1]), 24'(q[0])};
      phase_va <= {24'(s[2]), 24'(s[1]), 24'(s[0])};
      wr(meter_pkg::ADDR_CLEAR, 64'h1);
      wr(meter_pkg::ADDR_ACC_BASE, meter_pkg::ENERGY_WRAP_WS - 64'hA);
      wr(meter_pkg::ADDR_ACC_BASE + 16'h0012, 64'h5);
      wtick();
      @(posedge mclk);
      phase_volts <= {16'(v[2]), 16'(v[1]), 16'(v[0])};
      wtick();
      wtick();
      @(posedge mclk);
      phase_volts <= 48'h0;
      sm = w[0] + w[1];
      e = '{default: 0};
      e[0] = meter_pkg::ENERGY_WRAP_WS - 10 + 2 * w[0] - meter_pkg::ENERGY_WRAP_WS;
      e[1] = 2 * w[1];
      e[3] = 2 * w[0];
      e[7] = -2 * w[1];
      e[15] = -2 * sm;
      e[18] = -2 * sm;
      for (int p = 0; p < 2; p++) begin
         e[9 + p] = 2 * q[p];
         e[12 + p] = 2 * s[p];
         e[16] += 2 * q[p];
         e[17] += 2 * s[p];
      end
      for (int i = 0; i < 19; i++) rdc(meter_pkg::ADDR_ACC_BASE + 16'(i), e[i]);
      $display("test accumulation done");
      wr(meter_pkg::ADDR_CLEAR, 64'h2);
      rdc(meter_pkg::ADDR_ACC_BASE + 16'h0003, e[3]);
      wr(meter_pkg::ADDR_CLEAR, 64'h1);
      for (int i = 0; i < 18; i++) rdc(meter_pkg::ADDR_ACC_BASE + 16'(i), 64'h0);
      rdc(meter_pkg::ADDR_ACC_BASE + 16'h0012, e[18]);
      rdc(meter_pkg::ADDR_CLEAR, 64'h0);
      $display("test clear done");
      fr = 4500 + rnd(2000);
      phase_volts <= {16'(v[2]), 16'(v[1]), 16'(v[0])};
      freq_centi_hz <= 16'(fr);
      for (int j = 0; j < 4; j++) begin
         wr(meter_pkg::ADDR_SERVICE, 64'(j));
         wr(meter_pkg::ADDR_PWR_SCALE, k[j]);
         wr(meter_pkg::ADDR_PWR_SCALE, 64'h7);
         repeat (3) @(posedge mclk);
         ab = (v[0] + v[1]) * f[j] >> 9;
         bc = (v[1] + v[2]) * f[j] >> 9;
         ca = (v[2] + v[0]) * f[j] >> 9;
         rdc(meter_pkg::ADDR_PWR_SCALE, k[j]);
         rdc(meter_pkg::ADDR_LL_BASE, ab);
         rdc(meter_pkg::ADDR_AVG_LL, (ab + bc + ca) / 3);
         rdc(meter_pkg::ADDR_TOTAL_VARS_INT, sc(q[0] + q[1], k[j]));
         rdc(meter_pkg::ADDR_TOTAL_VA, sc(s[0] + s[1], k[j]));
         rdc(meter_pkg::ADDR_VARS_BASE + 16'h0002, 64'h0);
      end
      rdc(meter_pkg::ADDR_AVG_LN, (v[0] + v[1]) / 2);
      rdc(meter_pkg::ADDR_FREQ, fr / 10);
      for (int p = 0; p < 3; p++) rdc(meter_pkg::ADDR_PF_BASE + 16'(p), pf(w[p], s[p], p < 2));
      rdc(meter_pkg::ADDR_PF_AVG, pf(sm, s[0] + s[1], 1'b1));
      phase_watts[23:0] <= 24'h000000;
      repeat (3) @(posedge mclk);
      rdc(meter_pkg::ADDR_PF_BASE, 64'd100);
      $display("test results done");
      conclude();
   end
endmodule
`default_nettype wire
